// File: inc/tick_timer_pkg.sv
// constants of the low-frequency interval tick timer
// assumes an APB master with 32-bit data and a 16-bit byte address
package tick_timer_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CLOCK_GATE = 16'h0F76;
  localparam logic [15:0] IDX_CONTROL = 16'h0FC8;
  localparam logic [15:0] IDX_STATUS = 16'h0FC9;
  localparam logic [15:0] IDX_MASK = 16'h0FCA;
  localparam logic [15:0] ADDR_CLOCK_GATE = {IDX_CLOCK_GATE[13:0], 2'h0};
  localparam logic [15:0] ADDR_CONTROL = {IDX_CONTROL[13:0], 2'h0};
  localparam logic [15:0] ADDR_STATUS = {IDX_STATUS[13:0], 2'h0};
  localparam logic [15:0] ADDR_MASK = {IDX_MASK[13:0], 2'h0};
  // field positions
  localparam int GATE_BIT = 5;
  localparam int RUN_BIT = 0;
  localparam int SEL_LSB = 1;
  localparam int SEL_MSB = 3;
  localparam int TICK_EVENT_BIT = 0;
  // reset values
  localparam logic [7:0] CLOCK_GATE_RESET = 8'h00;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic RUN_RESET = 1'b0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] STATUS_USED = 8'h01;
  // counter width: longest period is 2^15 low-frequency cycles
  localparam int COUNT_W = 15;
  localparam logic [14:0] COUNT_ALL_ONES = 15'h7FFF;
  localparam int SYNC_W = 4;
endpackage

// File: rtl/tick_sync.sv
// two-flop synchroniser for the level inputs of the tick timer
// assumes inputs are quasi-static levels or a slow clock
`timescale 1ns/1ps
module tick_sync
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // levels
  input wire logic [tick_timer_pkg::SYNC_W-1:0] async_i,
  output logic [tick_timer_pkg::SYNC_W-1:0] sync_o
);
  logic [tick_timer_pkg::SYNC_W-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage1 <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

// File: rtl/lowfreq_interval_tick_timer.sv
// interval tick timer counting the low-frequency clock, APB slave
// assumes the low-frequency clock is far slower than MCLK_I
// Function
// RL1: setting run starts the counter on low-frequency edges when gated on
// RL2: interval code 000 gives 2^15 cycles, each step halves, 111 gives 2^8
// RL3: at each interval raise the interrupt and keep counting unreloaded
// RL4: clearing run zeroes the counter and stops counting
// RL5: interval writes are taken only while run is 0
// RL6: a write setting run updates interval; one clearing run does not
// RL7: oscillator off, stop or deepest sleep clears run, keeps interval
// RL8: clock gate 0 makes the block inoperative, 1 lets it operate
// RL9: reset sets the clock gate bit and run bit to 0
// RL10: software enables the clock gate before touching control
// RL11: software must not clear the clock gate while running
// RL12: interrupt is a one-cycle pulse on the selected bit toggling
// RL13: control bits 7 to 4 read zero and ignore writes
`timescale 1ns/1ps
module lowfreq_interval_tick_timer
(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // system levels, asynchronous
  input wire logic LOW_FREQUENCY_CLOCK_I,
  input wire logic LOWFREQ_OSC_ENABLE_I,
  input wire logic STOP_MODE_I,
  input wire logic DEEPEST_SLEEP_MODE_I,
  // timer outputs
  output logic TICK_INTERRUPT_O,
  output logic TICK_IRQ_O,
  output logic TICK_RUN_O
);
  typedef enum logic {APB_IDLE, APB_ANSWER} apb_state_type;

  function automatic logic [14:0] interval_mask(input logic [2:0] sel);
    interval_mask = tick_timer_pkg::COUNT_ALL_ONES >> sel;
  endfunction

  function automatic logic is_mapped(input logic [15:0] addr);
    is_mapped = (addr == tick_timer_pkg::ADDR_CLOCK_GATE) ||
                (addr == tick_timer_pkg::ADDR_CONTROL) ||
                (addr == tick_timer_pkg::ADDR_STATUS) ||
                (addr == tick_timer_pkg::ADDR_MASK);
  endfunction

  // synchronised levels
  logic [tick_timer_pkg::SYNC_W-1:0] sync_in;
  logic lf_sync;
  logic osc_en_sync;
  logic stop_sync;
  logic sleep_sync;

  tick_sync u_sync
  (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .async_i({DEEPEST_SLEEP_MODE_I, STOP_MODE_I, LOWFREQ_OSC_ENABLE_I,
              LOW_FREQUENCY_CLOCK_I}),
    .sync_o(sync_in)
  );

  assign lf_sync = sync_in[0];
  assign osc_en_sync = sync_in[1];
  assign stop_sync = sync_in[2];
  assign sleep_sync = sync_in[3];

  // state
  apb_state_type apb_state;
  apb_state_type next_apb_state;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [7:0] clock_gate_reg;
  logic [7:0] next_clock_gate_reg;
  logic [2:0] tick_sel;
  logic [2:0] next_tick_sel;
  logic tick_run;
  logic next_tick_run;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] mask;
  logic [7:0] next_mask;
  logic next_irq;
  logic lf_prev;
  logic [14:0] count;
  logic [14:0] next_count;
  logic next_tick;
  logic gate_on;
  logic lf_rise;
  logic wr_done;
  logic [14:0] count_inc;

  assign gate_on = clock_gate_reg[tick_timer_pkg::GATE_BIT];
  assign lf_rise = lf_sync & ~lf_prev;
  assign count_inc = count + 15'h0001;
  // a write lands only on the edge where pready is sampled high
  assign wr_done = (apb_state == APB_ANSWER) & PSEL_I & PENABLE_I &
                   PWRITE_I;

  // bus answer: one wait state, then pready for one cycle
  always_comb
  begin
    next_apb_state = apb_state;
    next_prdata = PRDATA_O;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    case (apb_state)
      APB_IDLE:
      begin
        if (PSEL_I && PENABLE_I)
        begin
          next_apb_state = APB_ANSWER;
          next_pready = 1'b1;
          next_pslverr = ~is_mapped(PADDR_I);
          next_prdata = 32'h00000000;
          if (!PWRITE_I)
          begin
            case (PADDR_I)
              tick_timer_pkg::ADDR_CLOCK_GATE:
                next_prdata[7:0] = clock_gate_reg;
              // RL13 upper bits zero
              tick_timer_pkg::ADDR_CONTROL:
                next_prdata[3:0] = {tick_sel, tick_run};
              tick_timer_pkg::ADDR_STATUS:
                next_prdata[7:0] = status;
              tick_timer_pkg::ADDR_MASK:
                next_prdata[7:0] = mask;
              default:
                next_prdata = 32'h00000000;
            endcase
          end
        end
      end
      APB_ANSWER:
      begin
        next_apb_state = APB_IDLE;
      end
      default:
      begin
        next_apb_state = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      apb_state <= APB_IDLE;
      PRDATA_O <= 32'h00000000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      apb_state <= next_apb_state;
      PRDATA_O <= next_prdata;
      PREADY_O <= next_pready;
      PSLVERR_O <= next_pslverr;
    end
  end

  // control registers
  always_comb
  begin
    next_clock_gate_reg = clock_gate_reg;
    next_tick_sel = tick_sel;
    next_tick_run = tick_run;
    next_mask = mask;
    if (wr_done && PADDR_I == tick_timer_pkg::ADDR_CLOCK_GATE)
    begin
      next_clock_gate_reg = PWDATA_I[7:0];
    end
    if (wr_done && PADDR_I == tick_timer_pkg::ADDR_MASK)
    begin
      next_mask = PWDATA_I[7:0] & tick_timer_pkg::STATUS_USED;
    end
    // RL8 gate blocks control
    if (wr_done && gate_on && PADDR_I == tick_timer_pkg::ADDR_CONTROL)
    begin
      next_tick_run = PWDATA_I[tick_timer_pkg::RUN_BIT];
      // RL5 RL6 interval only while stopped
      if (!tick_run)
      begin
        next_tick_sel = PWDATA_I[tick_timer_pkg::SEL_MSB:
                                 tick_timer_pkg::SEL_LSB];
      end
    end
    // RL7 hardware stop wins over a write once run is set; a write setting run from 0 holds for one cycle
    if (tick_run && (!osc_en_sync || stop_sync || sleep_sync))
    begin
      next_tick_run = 1'b0;
    end
  end

  // RL9 reset values
  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      clock_gate_reg <= tick_timer_pkg::CLOCK_GATE_RESET;
      tick_sel <= tick_timer_pkg::SEL_RESET;
      tick_run <= tick_timer_pkg::RUN_RESET;
      mask <= tick_timer_pkg::MASK_RESET;
    end
    else
    begin
      clock_gate_reg <= next_clock_gate_reg;
      tick_sel <= next_tick_sel;
      tick_run <= next_tick_run;
      mask <= next_mask;
    end
  end

  // binary counter and tick
  always_comb
  begin
    next_count = count;
    next_tick = 1'b0;
    // RL4 stopped counter held at zero
    if (!tick_run)
    begin
      next_count = 15'h0000;
    end
    // RL1 count low-frequency edges
    else if (gate_on && lf_rise)
    begin
      next_count = count_inc;
      // RL2 RL3 RL12 pulse when selected bit wraps
      next_tick = (count_inc & interval_mask(tick_sel)) == 15'h0000;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      count <= 15'h0000;
      lf_prev <= 1'b0;
      TICK_INTERRUPT_O <= 1'b0;
    end
    else
    begin
      count <= next_count;
      lf_prev <= lf_sync;
      TICK_INTERRUPT_O <= next_tick;
    end
  end

  // sticky status, write one to clear; a new tick beats the clear
  always_comb
  begin
    next_status = status;
    if (wr_done && PADDR_I == tick_timer_pkg::ADDR_STATUS)
    begin
      next_status = status & ~PWDATA_I[7:0];
    end
    if (TICK_INTERRUPT_O)
    begin
      next_status[tick_timer_pkg::TICK_EVENT_BIT] = 1'b1;
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      status <= tick_timer_pkg::STATUS_RESET;
      TICK_IRQ_O <= 1'b0;
      TICK_RUN_O <= 1'b0;
    end
    else
    begin
      status <= next_status;
      TICK_IRQ_O <= next_irq;
      TICK_RUN_O <= next_tick_run;
    end
  end

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);

  property p_count_step;
    tick_run && gate_on && lf_rise |=> count == $past(count_inc);
  endproperty
  a_count_step: assert property (p_count_step) // RL1
    else $error("counter did not step on a low-frequency edge");

  property p_tick_period;
    TICK_INTERRUPT_O |-> (count & interval_mask(tick_sel)) == 15'h0000;
  endproperty
  a_tick_period: assert property (p_tick_period) // RL2 RL3
    else $error("tick off the selected interval");

  property p_tick_pulse;
    TICK_INTERRUPT_O |=> !TICK_INTERRUPT_O;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) // RL12
    else $error("tick longer than one cycle");

  property p_stopped_zero;
    !tick_run && !$past(tick_run) |-> count == 15'h0000;
  endproperty
  a_stopped_zero: assert property (p_stopped_zero) // RL4
    else $error("counter not zero while stopped");

  property p_sel_locked;
    tick_run |=> $stable(tick_sel);
  endproperty
  a_sel_locked: assert property (p_sel_locked) // RL5
    else $error("interval changed while running");

  property p_sel_with_start;
    wr_done && gate_on && !tick_run &&
      PADDR_I == tick_timer_pkg::ADDR_CONTROL
      |=> tick_sel == $past(PWDATA_I[3:1]);
  endproperty
  a_sel_with_start: assert property (p_sel_with_start) // RL6
    else $error("interval not taken while stopped");

  property p_hw_stop;
    tick_run && (stop_sync || sleep_sync || !osc_en_sync)
      |=> !tick_run && $stable(tick_sel);
  endproperty
  a_hw_stop: assert property (p_hw_stop) // RL7
    else $error("run not cleared by low-power entry");

  property p_gate_off;
    !gate_on |=> count == $past(count) && !TICK_INTERRUPT_O;
  endproperty
  a_gate_off: assert property (p_gate_off) // RL8
    else $error("counter moved with clock gate off");

  property p_reset_values;
    disable iff (1'b0)
    RST_I |=> !tick_run && !clock_gate_reg[tick_timer_pkg::GATE_BIT];
  endproperty
  a_reset_values: assert property (p_reset_values) // RL9
    else $error("reset left gate or run set");

  property p_upper_zero;
    PREADY_O && PADDR_I == tick_timer_pkg::ADDR_CONTROL && !PWRITE_I
      |-> PRDATA_O[7:4] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) // RL13
    else $error("control upper bits not zero");
endmodule

// File: verification/lowfreq_interval_tick_timer_tb.sv
// self-checking bench for the interval tick timer over APB
// assumes the design answers with one wait state and syncs its levels
`timescale 1ns/1ps
module lowfreq_interval_tick_timer_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic lfclk = 1'b0;
  logic osc_en = 1'b1;
  logic stop = 1'b0;
  logic sleep = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic tick;
  logic irq;
  logic run_o;
  int num_errors = 0;
  int compares = 0;
  int ticks = 0;
  int t0;
  logic [31:0] r;
  logic e;

  lowfreq_interval_tick_timer dut
  (
    .MCLK_I(mclk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .LOW_FREQUENCY_CLOCK_I(lfclk), .LOWFREQ_OSC_ENABLE_I(osc_en),
    .STOP_MODE_I(stop), .DEEPEST_SLEEP_MODE_I(sleep),
    .TICK_INTERRUPT_O(tick), .TICK_IRQ_O(irq), .TICK_RUN_O(run_o)
  );

  initial
  begin
    forever #10 mclk = ~mclk;
  end

  // a pulse longer than one cycle counts twice and shows up
  always @(posedge mclk)
    if (tick === 1'b1)
      ticks <= ticks + 1;

  task tally_and_finish;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, w, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      num_errors++;
      $display("wrong value at %0t: no ready", $time);
      tally_and_finish;
    end
    else
    begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({31'h0, e}, 32'h0, "write error");
  endtask

  task rd(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp, "read data");
    chk({31'h0, e}, 32'h0, "read error");
  endtask

  // half period of four cycles keeps each phase above the sync limit
  task edges(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      lfclk <= 1'b1;
      repeat (4) @(posedge mclk);
      lfclk <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
  endtask

  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({31'h0, run_o}, 32'h0, "run after reset");
    rd(tick_timer_pkg::ADDR_CLOCK_GATE, 32'h0);
    rd(tick_timer_pkg::ADDR_CONTROL, 32'h0);
    rd(tick_timer_pkg::ADDR_STATUS, 32'h0);
    rd(tick_timer_pkg::ADDR_MASK, 32'h0);
    wr(tick_timer_pkg::ADDR_CONTROL, 32'h0F);
    rd(tick_timer_pkg::ADDR_CONTROL, 32'h0);
    wr(tick_timer_pkg::ADDR_CLOCK_GATE, 32'h20);
    rd(tick_timer_pkg::ADDR_CLOCK_GATE, 32'h20);
    apb(1'b0, 16'h0100, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    for (int s = 0; s < 8; s++)
    begin
      wr(tick_timer_pkg::ADDR_CONTROL, {28'h0, s[2:0], 1'b0});
      rd(tick_timer_pkg::ADDR_CONTROL, {28'h0, s[2:0], 1'b0});
    end
    wr(tick_timer_pkg::ADDR_CONTROL, 32'hFF);
    rd(tick_timer_pkg::ADDR_CONTROL, 32'h0F);
    wr(tick_timer_pkg::ADDR_CONTROL, 32'h05);
    rd(tick_timer_pkg::ADDR_CONTROL, 32'h0F);
    edges(200);
    chk(ticks, 0, "early tick");
    wr(tick_timer_pkg::ADDR_CONTROL, 32'h04);
    rd(tick_timer_pkg::ADDR_CONTROL, 32'h0E);
    chk({31'h0, run_o}, 32'h0, "run cleared");
    edges(300);
    chk(ticks, 0, "tick while stopped");
    for (int s = 7; s >= 5; s--)
    begin
      wr(tick_timer_pkg::ADDR_CONTROL, {28'h0, s[2:0], 1'b1});
      t0 = ticks;
      edges((1 << (15 - s)) - 1);
      chk(ticks, t0, "tick too soon");
      edges(1);
      chk(ticks, t0 + 1, "tick period");
      if (s == 7)
      begin
        edges(256);
        chk(ticks, t0 + 2, "second tick");
      end
      wr(tick_timer_pkg::ADDR_CONTROL, 32'h0);
    end
    rd(tick_timer_pkg::ADDR_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr(tick_timer_pkg::ADDR_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    wr(tick_timer_pkg::ADDR_STATUS, 32'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    rd(tick_timer_pkg::ADDR_STATUS, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      wr(tick_timer_pkg::ADDR_CONTROL, 32'h0B);
      // run output launches on the write edge; look one edge later
      @(posedge mclk);
      chk({31'h0, run_o}, 32'h1, "run set");
      osc_en <= (k != 0);
      stop <= (k == 1);
      sleep <= (k == 2);
      repeat (6) @(posedge mclk);
      chk({31'h0, run_o}, 32'h0, "run dropped");
      rd(tick_timer_pkg::ADDR_CONTROL, 32'h0A);
      osc_en <= 1'b1;
      stop <= 1'b0;
      sleep <= 1'b0;
      repeat (6) @(posedge mclk);
    end
    // gate goes off only once run is already clear
    wr(tick_timer_pkg::ADDR_CLOCK_GATE, 32'h0);
    rd(tick_timer_pkg::ADDR_CLOCK_GATE, 32'h0);
    tally_and_finish;
  end
endmodule
